// file: seepr_cfg.svh
// constants for the serial eeprom slave
`ifndef SEEPR_CFG_SVH
`define SEEPR_CFG_SVH
// ==========================================
// control byte layout
// type code value is arbitrary
`define SEEPR_TYPE_CODE 4'h5
`define SEEPR_TYPE_MSB 7
`define SEEPR_TYPE_LSB 4
`define SEEPR_DIR_BIT 0
// ==========================================
// memory shape
`define SEEPR_ADDR_W 8
`define SEEPR_PAGE_W 3
`define SEEPR_PAGE_BYTES 8
// ==========================================
// write cycle timing
`define SEEPR_CLK_MHZ 200
`define SEEPR_TWR_US 10000
`define SEEPR_TWR_CYC (`SEEPR_TWR_US * `SEEPR_CLK_MHZ)
`endif

// file: seepr_pkg.sv
// types for the serial eeprom slave
package seepr_pkg;
  // ==========================================
  // slave states
  typedef enum logic [2:0] {
    SEEPR_IDLE,
    SEEPR_CTRL,
    SEEPR_ADDR,
    SEEPR_WDATA,
    SEEPR_RDATA,
    SEEPR_RACK
  } seepr_state_t;
endpackage : seepr_pkg

// file: seepr_mem.sv
// byte array with registered read port
`timescale 1ns/10ps
`include "seepr_cfg.svh"
module seepr_mem #(
  parameter int DEPTH = 256
) (
  // clock
  input wire logic clk_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [`SEEPR_ADDR_W-1:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  // read port
  input wire logic [`SEEPR_ADDR_W-1:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  // ==========================================
  // write and registered read
  always_ff @(posedge clk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i[AW-1:0]] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i[AW-1:0]];
  end
endmodule : seepr_mem

// file: seepr_sync.sv
// two flop synchroniser for pin inputs
`timescale 1ns/10ps
module seepr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  // ==========================================
  // two stages, first read only by second
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_reg <= INIT;
      q_o <= INIT;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule : seepr_sync

// file: seepr_slave.sv
// two-wire serial eeprom slave command logic
// What this block does
// RULE1: match type code, ignore three select bits
// RULE2: master sends write control byte after start
// RULE3: acknowledge matching write control on ninth clock
// RULE4: next byte loads address pointer, acknowledged
// RULE5: stop after write data starts busy cycle
// RULE6: buffer up to eight bytes, commit at stop
// RULE7: increment only low three pointer bits
// RULE8: over eight bytes wrap, newest kept
// RULE9: host keeps page writes inside one page
// RULE10: master polls with control byte for ack
// RULE11: no control acknowledge while write busy
// RULE12: write protect high blocks all writes
// RULE13: write protect never affects reads
// RULE14: read control byte has direction one
// RULE15: pointer holds last address plus one, wrapping inside the page after a write
// RULE16: ack read control, send bytes until nack
// RULE17: random read sets pointer before restart
// RULE18: master ack fetches next sequential byte
// RULE19: sequential read pointer spans whole array
// RULE20: data line only pulled low or released
// RULE21: data change with clock high is condition
// RULE22: unused select pins have no effect
// RULE23: array is 128 or 256 bytes
// RULE24: write cycle timed by parameter counter
// RULE25: start resyncs to control, stop idles
`timescale 1ns/10ps
`include "seepr_cfg.svh"
module seepr_slave #(
  parameter int MEM_BYTES = 256,
  parameter int TWR_CYCLES = `SEEPR_TWR_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic ARST_N_I,
  // two-wire bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // pins
  input wire logic WP_I,
  input wire logic [2:0] UNUSED_SELECT_PINS_I,
  // status
  output logic BUSY_O
);
  localparam logic [7:0] AMASK = (MEM_BYTES == 128) ? 8'h7f : 8'hff;
  localparam int PB = `SEEPR_PAGE_BYTES;
  // ==========================================
  // pin synchronisers
  logic scl_s, sda_s, wp_s;
  logic scl_d_reg, sda_d_reg;
  seepr_sync #(.W(3), .INIT(3'h7)) u_sync (
    .clk_i(CLOCK_I),
    .arst_n_i(ARST_N_I),
    .d_i({SCL_I, SDA_I, WP_I}),
    .q_o({scl_s, sda_s, wp_s})
  );
  // edge history
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  logic scl_rise, scl_fall, start_c, stop_c;
  // conditions: data edge with clock high [RULE21]
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s; // [RULE21]
  assign stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s; // [RULE21]

  // control byte decode, select bits dropped [RULE1] [RULE22]
  function automatic logic ctrl_match(input logic [7:0] b);
    ctrl_match = (b[`SEEPR_TYPE_MSB:`SEEPR_TYPE_LSB] == `SEEPR_TYPE_CODE);
  endfunction : ctrl_match

  // ==========================================
  // bit engine
  seepr_pkg::seepr_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic ack_phase;
  logic [7:0] rx_byte;
  logic byte_done;
  logic busy_reg;
  logic [7:0] ptr_reg;
  logic [7:0] page_buf [PB];
  logic [PB-1:0] page_vld_reg;
  logic [`SEEPR_PAGE_W-1:0] commit_idx_reg;
  logic committing_reg;
  logic ack_drive_reg;
  logic tx_low_reg;
  logic [7:0] rd_data;
  logic [31:0] twr_cnt_reg;

  assign ack_phase = (bit_cnt_reg == 4'h8);
  assign rx_byte = shift_reg;
  // byte complete at the eighth fall, so an ack starts with the clock low
  assign byte_done = scl_fall && (bit_cnt_reg == 4'h7);

  // bit counter and receive shifter
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
    end else if (start_c) begin
      // all ones: the clock fall after the start wraps it to zero
      bit_cnt_reg <= 4'hf;
    end else if (scl_rise && !ack_phase) begin
      shift_reg <= {shift_reg[6:0], sda_s};
    end else if (scl_fall) begin
      bit_cnt_reg <= ack_phase ? 4'h0 : bit_cnt_reg + 4'h1;
    end
  end

  // ==========================================
  // command state machine
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      state_reg <= seepr_pkg::SEEPR_IDLE;
      ack_drive_reg <= 1'b0;
    end else if (start_c) begin
      state_reg <= seepr_pkg::SEEPR_CTRL; // [RULE25]
      ack_drive_reg <= 1'b0;
    end else if (stop_c) begin
      state_reg <= seepr_pkg::SEEPR_IDLE; // [RULE25]
      ack_drive_reg <= 1'b0;
    end else begin
      case (state_reg)
        seepr_pkg::SEEPR_CTRL: begin
          if (byte_done) begin
            // no acknowledge while busy [RULE3] [RULE11]
            if (ctrl_match(rx_byte) && !busy_reg) begin
              ack_drive_reg <= 1'b1;
              state_reg <= rx_byte[`SEEPR_DIR_BIT] ? seepr_pkg::SEEPR_RDATA
                                                   : seepr_pkg::SEEPR_ADDR;
            end else begin
              state_reg <= seepr_pkg::SEEPR_IDLE;
            end
          end
        end
        seepr_pkg::SEEPR_ADDR, seepr_pkg::SEEPR_WDATA: begin
          if (byte_done) begin
            ack_drive_reg <= 1'b1; // [RULE4]
            state_reg <= seepr_pkg::SEEPR_WDATA;
          end
        end
        seepr_pkg::SEEPR_RDATA: begin
          if (scl_fall && ack_phase) begin
            ack_drive_reg <= 1'b0;
          end else if (byte_done) begin
            // leave only after bit 0 was held through its clock
            state_reg <= seepr_pkg::SEEPR_RACK;
          end
        end
        seepr_pkg::SEEPR_RACK: begin
          // master ack continues, nack stops [RULE16] [RULE18]
          if (scl_rise && ack_phase) begin
            state_reg <= sda_s ? seepr_pkg::SEEPR_IDLE : seepr_pkg::SEEPR_RDATA;
          end
        end
        default: begin
          state_reg <= state_reg;
        end
      endcase
      if (state_reg != seepr_pkg::SEEPR_RDATA && scl_fall && ack_phase) begin
        ack_drive_reg <= 1'b0;
      end
    end
  end

  // ==========================================
  // address pointer
  logic in_read;
  assign in_read = (state_reg == seepr_pkg::SEEPR_RDATA);
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ptr_reg <= 8'h00;
    end else if (state_reg == seepr_pkg::SEEPR_ADDR && byte_done) begin
      ptr_reg <= rx_byte & AMASK; // [RULE4] [RULE17] [RULE23]
    end else if (state_reg == seepr_pkg::SEEPR_WDATA && byte_done) begin
      // page roll inside the current page [RULE7] [RULE8]
      ptr_reg <= {ptr_reg[7:`SEEPR_PAGE_W], ptr_reg[`SEEPR_PAGE_W-1:0] + 3'h1};
    end else if (in_read && scl_fall && ack_phase) begin
      // byte loaded, advance over whole array [RULE15] [RULE19]
      ptr_reg <= (ptr_reg + 8'h01) & AMASK;
    end
  end

  // ==========================================
  // page buffer
  logic [7:0] page_base_reg;
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      page_vld_reg <= '0;
      page_base_reg <= 8'h00;
      for (int i = 0; i < PB; i++) begin
        page_buf[i] <= 8'h00;
      end
    end else if (state_reg == seepr_pkg::SEEPR_CTRL && byte_done) begin
      page_vld_reg <= '0;
    end else if (state_reg == seepr_pkg::SEEPR_WDATA && byte_done) begin
      // newest byte overwrites a wrapped slot [RULE6] [RULE8]
      page_buf[ptr_reg[`SEEPR_PAGE_W-1:0]] <= rx_byte;
      page_vld_reg[ptr_reg[`SEEPR_PAGE_W-1:0]] <= 1'b1;
      page_base_reg <= {ptr_reg[7:`SEEPR_PAGE_W], 3'h0};
    end else if (committing_reg) begin
      page_vld_reg[commit_idx_reg] <= 1'b0;
    end
  end

  // ==========================================
  // self-timed write cycle
  logic wr_stop;
  assign wr_stop = stop_c && state_reg == seepr_pkg::SEEPR_WDATA && (page_vld_reg != '0);
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      busy_reg <= 1'b0;
      twr_cnt_reg <= 32'h0;
      committing_reg <= 1'b0;
      commit_idx_reg <= 3'h0;
    end else if (wr_stop && !busy_reg) begin
      busy_reg <= 1'b1; // [RULE5]
      twr_cnt_reg <= 32'(TWR_CYCLES - 1); // [RULE24]
      committing_reg <= 1'b1;
      commit_idx_reg <= 3'h0;
    end else if (busy_reg) begin
      if (committing_reg) begin
        commit_idx_reg <= commit_idx_reg + 3'h1;
        committing_reg <= (commit_idx_reg != 3'h7);
      end
      if (twr_cnt_reg == 32'h0) begin
        busy_reg <= 1'b0; // [RULE24]
      end else begin
        twr_cnt_reg <= twr_cnt_reg - 32'h1;
      end
    end
  end
  assign BUSY_O = busy_reg;

  // commit only when write protect is low [RULE6] [RULE12]
  logic mem_we;
  assign mem_we = committing_reg && page_vld_reg[commit_idx_reg] && !wp_s; // [RULE12]
  seepr_mem #(.DEPTH(MEM_BYTES)) u_mem (
    .clk_i(CLOCK_I),
    .wr_en_i(mem_we),
    .wr_addr_i(page_base_reg | {5'h00, commit_idx_reg}),
    .wr_data_i(page_buf[commit_idx_reg]),
    .rd_addr_i(ptr_reg),
    .rd_data_o(rd_data)
  );

  // ==========================================
  // transmit: reads ignore write protect [RULE13]
  logic [7:0] tx_shift_reg;
  always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tx_shift_reg <= 8'hff;
      tx_low_reg <= 1'b0;
    end else if (start_c || stop_c || !in_read) begin
      tx_low_reg <= 1'b0;
      tx_shift_reg <= rd_data;
    end else if (scl_fall && ack_phase) begin
      tx_low_reg <= !rd_data[7];
      tx_shift_reg <= {rd_data[6:0], 1'b1};
    end else if (scl_fall && bit_cnt_reg < 4'h7) begin
      tx_low_reg <= !tx_shift_reg[7];
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
    end else if (scl_fall) begin
      tx_low_reg <= 1'b0;
    end
  end

  // open drain: pull low or release [RULE20]
  assign SDA_O = 1'b0;
  assign SDA_OE_O = ack_drive_reg || tx_low_reg; // [RULE20]

  // ==========================================
  // checks
  busy_no_ack_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE11]
    (state_reg == seepr_pkg::SEEPR_CTRL && byte_done && busy_reg) |=> !ack_drive_reg)
    else $error("ack given while busy");
  wp_no_write_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE12]
    wp_s |-> !mem_we)
    else $error("write while protected");
  page_roll_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE7]
    (state_reg == seepr_pkg::SEEPR_WDATA && byte_done) |=>
    ptr_reg[7:3] == $past(ptr_reg[7:3]))
    else $error("page bits moved");
  stop_busy_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE5]
    (wr_stop && !busy_reg) |=> busy_reg [*2])
    else $error("no write cycle");
  start_ctrl_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE25]
    start_c |=> state_reg == seepr_pkg::SEEPR_CTRL)
    else $error("start not resync");
  stop_idle_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE25]
    (stop_c && !start_c) |=> state_reg == seepr_pkg::SEEPR_IDLE)
    else $error("stop not idle");
  never_high_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE20]
    SDA_OE_O |-> !SDA_O)
    else $error("sda driven high");
  oe_clk_low_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE21]
    $changed(SDA_OE_O) |-> !scl_s)
    else $error("data moved with clock high");
  ctrl_ack_a: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I) // [RULE3]
    (state_reg == seepr_pkg::SEEPR_CTRL && byte_done && !busy_reg && !start_c
     && !stop_c && ctrl_match(rx_byte)) |=> ack_drive_reg)
    else $error("match not acked");
endmodule : seepr_slave

// file: seepr_master.sv
// two-wire bus master model driving clock and conditions
`timescale 1ns/10ps
module seepr_master (
  // bus lines
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  // ==========================================
  // idle bus: clock high, data released
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // data falls while clock high, clock then left low
  task automatic start_cond();
    #22 sda_pull_o = 1'b0;
    #13 scl_o = 1'b1;
    #25 sda_pull_o = 1'b1;
    #25 scl_o = 1'b0;
  endtask : start_cond
  // data rises while clock high, bus left idle
  task automatic stop_cond();
    #22 sda_pull_o = 1'b1;
    #13 scl_o = 1'b1;
    #25 sda_pull_o = 1'b0;
    #25;
  endtask : stop_cond
  // one clock: data set in low phase, sampled mid high
  task automatic bit_cycle(input logic pull, output logic seen);
    #22 sda_pull_o = pull;
    #8 scl_o = 1'b1;
    #9 seen = sda_i;
    #9 scl_o = 1'b0;
  endtask : bit_cycle
  // byte msb first, nack = 1 when ninth clock is not pulled low
  task automatic put_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(~b[i], nack);
    end
    bit_cycle(1'b0, nack);
  endtask : put_byte
  // byte from the slave, acked unless last
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_cycle(1'b0, s);
      b = {b[6:0], s};
    end
    bit_cycle(~last, s);
  endtask : get_byte
endmodule : seepr_master

// file: seepr_slave_test.sv
// self-checking bench for the serial eeprom slave
`timescale 1ns/10ps
`include "seepr_cfg.svh"
module seepr_slave_test;
  localparam int TWR = 200;
  logic clk, arst_n, scl, pull, sda, sda_o, sda_oe, wp, busy, nk;
  logic [2:0] sel;
  logic [7:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;
  // ==========================================
  // open-drain wire with pull-up
  assign sda = (pull || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  seepr_slave #(.MEM_BYTES(256), .TWR_CYCLES(TWR)) uut (
    .CLOCK_I(clk), .ARST_N_I(arst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .WP_I(wp), .UNUSED_SELECT_PINS_I(sel), .BUSY_O(busy));
  seepr_master m (.scl_o(scl), .sda_pull_o(pull), .sda_i(sda));
  // ==========================================
  // compare and report
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results
  function automatic logic [7:0] ctl(input logic [2:0] s, input logic d);
    return {4'(`SEEPR_TYPE_CODE), s, d};
  endfunction : ctl
  // bounded wait for the write cycle to end
  task automatic wait_idle();
    for (int i = 0; i < 4 * TWR && busy !== 1'b0; i++) @(posedge clk);
    if (busy !== 1'b0) begin
      $display("BAD busy timeout expected 0 seen %b", busy);
      n_mismatch++;
      results();
    end
  endtask : wait_idle
  // start, write control, word address
  task automatic set_ptr(input logic [7:0] a);
    m.start_cond();
    m.put_byte(ctl(3'h5, 1'b0), nk);
    check("control ack", {7'h0, nk}, 8'h00);
    m.put_byte(a, nk);
    check("address ack", {7'h0, nk}, 8'h00);
  endtask : set_ptr
  // n data bytes first+i from address a, then stop
  task automatic write_run(input logic [7:0] a, input logic [7:0] first, input int n);
    set_ptr(a);
    for (int i = 0; i < n; i++) begin
      m.put_byte(first + 8'(i), nk);
      check("data ack", {7'h0, nk}, 8'h00);
    end
    m.stop_cond();
    repeat (4) @(posedge clk);
    #1 check("busy after stop", {7'h0, busy}, 8'h01);
  endtask : write_run
  // start or repeated start, read control, n bytes expected first+i
  task automatic read_run(input logic [7:0] first, input int n);
    m.start_cond();
    m.put_byte(ctl(3'h2, 1'b1), nk);
    check("read control ack", {7'h0, nk}, 8'h00);
    for (int i = 0; i < n; i++) begin
      m.get_byte(i == n - 1, rd);
      check("read byte", rd, first + 8'(i));
    end
    m.stop_cond();
  endtask : read_run
  // ==========================================
  // scenarios
  task automatic t_byte_write();
    write_run(8'h20, 8'ha5, 1);
    m.start_cond();
    m.put_byte(ctl(3'h0, 1'b0), nk);
    check("poll while busy", {7'h0, nk}, 8'h01);
    m.stop_cond();
    wait_idle();
    m.start_cond();
    m.put_byte(ctl(3'h7, 1'b0), nk);
    check("poll when done", {7'h0, nk}, 8'h00);
    m.stop_cond();
    set_ptr(8'h20);
    read_run(8'ha5, 1);
    $display("byte write and polling done");
  endtask : t_byte_write
  task automatic t_page_wrap();
    write_run(8'h1e, 8'hd0, 10);
    wait_idle();
    set_ptr(8'h18);
    read_run(8'hd2, 8);
    read_run(8'ha5, 1);
    $display("page wrap and sequential read done");
  endtask : t_page_wrap
  task automatic t_protect();
    @(posedge clk);
    #1 wp = 1'b1;
    write_run(8'h20, 8'h3c, 1);
    wait_idle();
    set_ptr(8'h20);
    read_run(8'ha5, 1);
    @(posedge clk);
    #1 wp = 1'b0;
    $display("write protect done");
  endtask : t_protect
  task automatic t_bad_code();
    @(posedge clk);
    #1 sel = 3'h0;
    m.start_cond();
    m.put_byte({4'(`SEEPR_TYPE_CODE) ^ 4'h3, 3'h0, 1'b0}, nk);
    check("foreign code", {7'h0, nk}, 8'h01);
    m.stop_cond();
    set_ptr(8'h20);
    read_run(8'ha5, 1);
    $display("type code mismatch done");
  endtask : t_bad_code
  // ==========================================
  // main sequence
  initial begin
    arst_n = 1'b0;
    wp = 1'b0;
    sel = 3'h7;
    repeat (16) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (8) @(posedge clk);
    t_byte_write();
    t_page_wrap();
    t_protect();
    t_bad_code();
    results();
  end
  // hang guard
  initial begin
    #400000;
    $display("BAD run time expected end seen timeout");
    n_mismatch++;
    results();
  end
endmodule : seepr_slave_test
